/* mlsg_map.svh */
// Offsets, field positions, reset values and timing counts of the guard
`ifndef MLSG_MAP_SVH
`define MLSG_MAP_SVH
`define MLSG_CLK_KHZ 125000
// Stall period: 120 s per uF, 0.068 uF part
`define MLSG_STALL_S_PER_UF 120
`define MLSG_STALL_CAP_NF 68
`define MLSG_STALL_MS (`MLSG_STALL_S_PER_UF * `MLSG_STALL_CAP_NF)
`define MLSG_STALL_CYC (`MLSG_STALL_MS * `MLSG_CLK_KHZ)
// Mask time: 0.9 s per uF, 0.1 uF part
`define MLSG_MASK_MS_PER_UF 900
`define MLSG_MASK_CAP_NF 100
`define MLSG_MASK_MS (`MLSG_MASK_MS_PER_UF * `MLSG_MASK_CAP_NF / 1000)
`define MLSG_MASK_CYC (`MLSG_MASK_MS * `MLSG_CLK_KHZ)
// Register offsets
`define MLSG_OFS_STALL 12'h000
`define MLSG_OFS_MASK 12'h004
`define MLSG_OFS_WIN 12'h008
`define MLSG_OFS_STAT 12'h00C
`define MLSG_OFS_IRQ 12'h010
`define MLSG_OFS_IEN 12'h014
// Status fields
`define MLSG_ST_LOCK 0
`define MLSG_ST_IND 1
`define MLSG_ST_STALL 2
`define MLSG_ST_SAVE 3
// Reset values
`define MLSG_WIN_RST 16'h0100
`define MLSG_IEN_RST 3'h0
`endif

/* mlsg_pkg.sv */
// Types shared by the lock mask and stall guard
package mlsg_pkg;
   typedef enum logic [1:0] {
      MLSG_IDLE = 2'b00,
      MLSG_TIMING = 2'b01,
      MLSG_LATCHED = 2'b10
   } mlsg_stall_state_t;
   // Interrupt events, same layout in status and mask
   typedef struct packed {
      logic lock_gained;
      logic lock_lost;
      logic stall;
   } mlsg_evt_t;
endpackage : mlsg_pkg

/* mlsg_top.sv */
// Lock indicator mask filter and stall guard with APB registers
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`include "mlsg_map.svh"

// All delays are counted on clock_in. Capacitors set them in the analog
// part; here software writes the counts, so the reset values are only the
// nominal figures, and a bench may shorten them freely.
// Limitation: a count of zero for the stall period latches only after about
// 2^32 unlocked cycles, since the compare wraps below zero.

// What this block does
// - Unlocked too long in start: low side off
// - Stall period set by programmable count
// - Stall timer idle during clock braking
// - Stall latch clears only by stop, grounded node or reset
// - Grounded stall node holds logic in reset
// - Select high masks short lock pulses
// - Lock level delayed by mask time
// - Select low masks short unlock pulses
// - Mask time set by programmable count
// - Zero mask time passes indicator through
// - Lock means phase lock, no speed bound
// - Compare falling edges of clock and feedback
// - Stop state enters power saving
module mlsg_top import mlsg_pkg::*; #(
   parameter logic [31:0] STALL_CYCLES = 32'(`MLSG_STALL_CYC),
   parameter logic [31:0] MASK_CYCLES = 32'(`MLSG_MASK_CYC)
) (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic ref_clock_in,
   input wire logic speed_feedback_input_in,
   input wire logic start_in,
   input wire logic brake_switch_in,
   input wire logic lock_mask_select_in,
   input wire logic stall_timer_node_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   output logic lock_indicator_out,
   output logic low_side_enable_out,
   output logic power_save_out,
   output logic speed_control_on_out,
   output logic irq_out
);
   logic run; // Speed control active
   logic ref_q, fb_q; // Previous input levels
   logic ref_fall, fb_fall; // Falling edge strobes
   logic [15:0] phase_q; // Cycles since last clock fall
   logic locked_q; // Raw phase lock, 1 = locked
   logic ind_q; // Masked indicator, 1 = unlocked
   logic [31:0] mcnt_q; // Mask timer
   logic [31:0] scnt_q; // Stall timer
   mlsg_stall_state_t st_q; // Stall guard state
   // Periods are in cycles of clock_in
   logic [31:0] stall_per_q; // Stall period register
   logic [31:0] mask_per_q; // Mask time register, zero = no capacitor
   logic [15:0] win_q; // Lock window in cycles after a clock fall
   mlsg_evt_t irq_q; // Sticky event bits
   mlsg_evt_t ien_q; // Event mask, same layout
   mlsg_evt_t evt; // Events seen in this cycle
   logic wr; // Write in the access phase
   logic acc; // Access phase of a transfer
   logic hit; // Address decodes to a register
   logic ind_prev_q; // Indicator one cycle ago, for event edges

   // Grounded stall node holds the logic in reset; stop parks it too
   // Node low is treated as a plain hold; no extra reset pulse is made
   assign run = start_in & stall_timer_node_in;
   assign power_save_out = ~start_in;
   assign speed_control_on_out = run;
   assign low_side_enable_out = run & (st_q != MLSG_LATCHED);
   // Indicator straight from its flip-flop, so no glitch reaches the pin
   assign lock_indicator_out = ind_q;
   // Edge strobes; history resets low so no false fall follows reset
   assign ref_fall = ref_q & ~ref_clock_in;
   assign fb_fall = fb_q & ~speed_feedback_input_in;

   // Edge history of the two pulse inputs
   // Inputs are taken as synchronous, so one stage is enough
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ref_q <= 1'b0;
         fb_q <= 1'b0;
      end else begin
         ref_q <= ref_clock_in;
         fb_q <= speed_feedback_input_in;
      end
   end

   // Phase comparator; no speed counter, so lock bounds no speed error
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         phase_q <= 16'h0000;
         locked_q <= 1'b0;
      end else if (!run) begin
         phase_q <= 16'h0000;
         locked_q <= 1'b0;
      end else begin
         // Saturate so a missing reference clock reads as far out of phase
         if (ref_fall) begin
            phase_q <= 16'h0000;
         end else if (phase_q != 16'hFFFF) begin
            phase_q <= phase_q + 16'h0001;
         end
         // Feedback fall near clock fall means lock
         // Only phase is judged; a slow rotor in phase still reads locked
         if (fb_fall) begin
            locked_q <= ref_fall | (phase_q <= win_q);
         end else if (phase_q == 16'hFFFF) begin
            locked_q <= 1'b0;
         end
      end
   end

   // Indicator mask filter
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ind_q <= 1'b1;
         mcnt_q <= 32'h0000_0000;
      end else if (!run) begin
         ind_q <= 1'b1;
         mcnt_q <= 32'h0000_0000;
      end else if (mask_per_q == 32'h0000_0000) begin
         ind_q <= ~locked_q;
         mcnt_q <= 32'h0000_0000;
      end else if (ind_q == ~locked_q) begin
         // Nothing pending: a bounce restarts the mask time from zero
         mcnt_q <= 32'h0000_0000;
      end else if (lock_mask_select_in == ind_q) begin
         // Change toward the masked level waits out the mask time
         if (mcnt_q >= mask_per_q - 32'h0000_0001) begin
            ind_q <= ~locked_q;
            mcnt_q <= 32'h0000_0000;
         end else begin
            mcnt_q <= mcnt_q + 32'h0000_0001;
         end
      end else begin
         // Change away from the masked level passes at once
         ind_q <= ~locked_q;
         mcnt_q <= 32'h0000_0000;
      end
   end

   // Stall guard state machine
   // Braking restarts the timer rather than pausing it, so a long brake
   // followed by a short unlock never adds up to a false stall
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_q <= MLSG_IDLE;
         scnt_q <= 32'h0000_0000;
      end else if (!run) begin
         st_q <= MLSG_IDLE;
         scnt_q <= 32'h0000_0000;
      end else begin
         unique case (st_q)
            MLSG_IDLE: begin
               scnt_q <= 32'h0000_0000;
               if (ind_q && !brake_switch_in) begin
                  st_q <= MLSG_TIMING;
               end
            end
            MLSG_TIMING: begin
               if (!ind_q || brake_switch_in) begin
                  st_q <= MLSG_IDLE;
                  scnt_q <= 32'h0000_0000;
               end else if (scnt_q >= stall_per_q - 32'h0000_0001) begin
                  st_q <= MLSG_LATCHED;
               end else begin
                  scnt_q <= scnt_q + 32'h0000_0001;
               end
            end
            MLSG_LATCHED: begin
               // Only stop, a grounded node (branch above) or reset leaves here
               st_q <= MLSG_LATCHED;
            end
            default: begin
               st_q <= MLSG_IDLE;
               scnt_q <= 32'h0000_0000;
            end
         endcase
      end
   end

   // APB decode; answers with no wait state
   // Read data is a plain mux, valid while the address is held
   assign acc = psel_in & penable_in;
   assign wr = acc & pwrite_in;
   assign pready_out = 1'b1;
   always_comb begin
      hit = 1'b1;
      prdata_out = 32'h0000_0000;
      unique case (paddr_in)
         `MLSG_OFS_STALL: prdata_out = stall_per_q;
         `MLSG_OFS_MASK: prdata_out = mask_per_q;
         `MLSG_OFS_WIN: prdata_out = {16'h0000, win_q};
         `MLSG_OFS_STAT: begin
            prdata_out[`MLSG_ST_LOCK] = locked_q;
            prdata_out[`MLSG_ST_IND] = ind_q;
            prdata_out[`MLSG_ST_STALL] = st_q == MLSG_LATCHED;
            prdata_out[`MLSG_ST_SAVE] = ~start_in;
         end
         `MLSG_OFS_IRQ: prdata_out = {29'h0, irq_q};
         `MLSG_OFS_IEN: prdata_out = {29'h0, ien_q};
         default: hit = 1'b0;
      endcase
   end
   assign pslverr_out = acc & ~hit;

   // Software registers; a write to an unmapped place changes nothing
   // Status and event places are not stored here
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stall_per_q <= STALL_CYCLES;
         mask_per_q <= MASK_CYCLES;
         win_q <= `MLSG_WIN_RST;
         ien_q <= `MLSG_IEN_RST;
      end else if (wr) begin
         if (paddr_in == `MLSG_OFS_STALL) stall_per_q <= pwdata_in;
         if (paddr_in == `MLSG_OFS_MASK) mask_per_q <= pwdata_in;
         if (paddr_in == `MLSG_OFS_WIN) win_q <= pwdata_in[15:0];
         if (paddr_in == `MLSG_OFS_IEN) ien_q <= pwdata_in[2:0];
      end
   end

   // Sticky events, write one to clear; a new event beats the clear
   // History resets to the indicator's own reset level: no false event
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ind_prev_q <= 1'b1;
      end else begin
         ind_prev_q <= ind_q;
      end
   end
   // Stall event is the very cycle the guard moves to latched
   always_comb begin
      evt.stall = st_q == MLSG_TIMING && scnt_q >= stall_per_q - 32'h1 &&
                  run && ind_q && !brake_switch_in;
      evt.lock_lost = ind_q & ~ind_prev_q;
      evt.lock_gained = ~ind_q & ind_prev_q;
   end
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_q <= '0;
      end else if (wr && paddr_in == `MLSG_OFS_IRQ) begin
         irq_q <= (irq_q & ~pwdata_in[2:0]) | evt;
      end else begin
         irq_q <= irq_q | evt;
      end
   end
   assign irq_out = |(irq_q & ien_q);

   // Checks of the guard, the filter and the events
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);

   property p_off;
      st_q == MLSG_LATCHED |-> !low_side_enable_out;
   endproperty
   a_off: assert property (p_off) else $error("drive on while latched");
   property p_unlk;
      $rose(st_q == MLSG_LATCHED) |-> $past(ind_q) && $past(run);
   endproperty
   a_unlk: assert property (p_unlk) else $error("latch without unlock");
   property p_per;
      $rose(st_q == MLSG_LATCHED) |-> $past(scnt_q) == stall_per_q - 32'h1;
   endproperty
   a_per: assert property (p_per) else $error("stall period wrong");
   property p_brk;
      brake_switch_in && st_q != MLSG_LATCHED |=> scnt_q == 32'h0;
   endproperty
   a_brk: assert property (p_brk) else $error("timer ran in braking");
   property p_hold;
      st_q == MLSG_LATCHED && run |=> st_q == MLSG_LATCHED;
   endproperty
   a_hold: assert property (p_hold) else $error("latch lost");
   property p_clr;
      !start_in |=> st_q == MLSG_IDLE && ind_q;
   endproperty
   a_clr: assert property (p_clr) else $error("stop did not clear");
   property p_node;
      !stall_timer_node_in |=> !locked_q ##0 scnt_q == 32'h0;
   endproperty
   a_node: assert property (p_node) else $error("node low, logic ran");
   property p_lkd;
      $fell(ind_q) && $past(lock_mask_select_in) && $past(mask_per_q) != 32'h0
         |-> $past(mcnt_q) == mask_per_q - 32'h1;
   endproperty
   a_lkd: assert property (p_lkd) else $error("lock not delayed");
   property p_ulk;
      $rose(ind_q) && !$past(lock_mask_select_in) && $past(run) &&
         $past(mask_per_q) != 32'h0 |-> $past(mcnt_q) == mask_per_q - 32'h1;
   endproperty
   a_ulk: assert property (p_ulk) else $error("unlock not masked");
   property p_pass;
      mask_per_q == 32'h0 && run |=> ind_q == !$past(locked_q);
   endproperty
   a_pass: assert property (p_pass) else $error("no pass-through");
   property p_ph;
      run && fb_fall && !ref_fall && phase_q > win_q |=> !locked_q;
   endproperty
   a_ph: assert property (p_ph) else $error("lock out of window");
   // An event must land in its sticky bit even under a clear
   property p_setw;
      evt.stall |=> irq_q.stall;
   endproperty
   a_setw: assert property (p_setw) else $error("stall event lost");
   property p_lgn;
      $fell(ind_q) |=> irq_q.lock_gained;
   endproperty
   a_lgn: assert property (p_lgn) else $error("lock gain event lost");
   property p_lost;
      $rose(ind_q) |=> irq_q.lock_lost;
   endproperty
   a_lost: assert property (p_lost) else $error("lock loss event lost");
   // Main scenarios
   c_latch: cover property ($rose(st_q == MLSG_LATCHED));
   c_lock: cover property ($fell(ind_q) && lock_mask_select_in);
   c_irq: cover property ($rose(irq_out));
   c_brake: cover property (brake_switch_in && run && ind_q);
   c_pass: cover property (mask_per_q == 32'h0 && run && !ind_q);
endmodule : mlsg_top

/* mlsg_host_model.sv */
// Host side model: reference clock and motor feedback pulse source
`timescale 1ns/1ns

module mlsg_host_model (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic fb_on_in,
   output logic ref_clock_out,
   output logic fb_out
);
   logic [4:0] ph_q; // Phase counter, one reference period is 32 cycles

   // Free running reference; feedback trails it by two cycles when spinning
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ph_q <= 5'h00;
      end else begin
         ph_q <= ph_q + 5'h01;
      end
   end
   assign ref_clock_out = (ph_q < 5'h10);
   // A stalled rotor gives a frozen feedback level, so no falling edges
   assign fb_out = fb_on_in ? (ph_q >= 5'h02 && ph_q < 5'h12) : 1'b1;
endmodule : mlsg_host_model

/* test_motor_lock_mask_and_stall_guard.sv */
// Bench for the lock mask filter and stall guard
`timescale 1ns/1ns

module test_motor_lock_mask_and_stall_guard;
   logic clk = 1'b0, rst_n = 1'b0, refc, fbk, fb_on = 1'b0;
   logic start = 1'b0, brake = 1'b0, sel = 1'b1, node = 1'b1;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [11:0] pad = 12'h000;
   logic [31:0] pwd = 32'h0000_0000, prd, rd;
   logic rdy, serr, lock, lse, psave, spd, irq, serr_q;
   int err_total = 0, n_compared = 0, i;

   always #4 clk = ~clk; // 125 MHz

   mlsg_host_model host_u (.clock_in(clk), .rst_n_in(rst_n), .fb_on_in(fb_on),
      .ref_clock_out(refc), .fb_out(fbk));

   // Short counts keep the run brief
   mlsg_top #(.STALL_CYCLES(32'h0000_0014), .MASK_CYCLES(32'h0000_0005)) dut_u (
      .clock_in(clk), .rst_n_in(rst_n), .ref_clock_in(refc), .speed_feedback_input_in(fbk),
      .start_in(start), .brake_switch_in(brake), .lock_mask_select_in(sel),
      .stall_timer_node_in(node), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
      .paddr_in(pad), .pwdata_in(pwd), .prdata_out(prd), .pready_out(rdy),
      .pslverr_out(serr), .lock_indicator_out(lock), .low_side_enable_out(lse),
      .power_save_out(psave), .speed_control_on_out(spd), .irq_out(irq));

   // One APB transfer; data and error taken at the edge where pready is seen
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      pad <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      rd = prd;
      serr_q = serr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb

   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask : chk

   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task report_and_stop;
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop

   // Watchdog: the tests need under a thousand cycles
   initial begin
      cyc(20000);
      err_total++;
      report_and_stop;
   end

   initial begin
      cyc(2);
      rst_n <= 1'b1;
      // Reset values and an unmapped place
      apb(1'b0, 12'h000, 0); chk(rd, 32'h0000_0014, "stall reset");
      apb(1'b0, 12'h004, 0); chk(rd, 32'h0000_0005, "mask reset");
      apb(1'b0, 12'h008, 0); chk(rd, 32'h0000_0100, "window reset");
      apb(1'b0, 12'h014, 0); chk(rd, 32'h0000_0000, "irq mask reset");
      apb(1'b1, 12'h020, 32'h0000_00FF); chk({31'h0, serr_q}, 1, "unmapped err");
      chk({31'h0, psave}, 1, "stop saves power");
      $display("test registers done");
      // Stall: brake holds the timer, then the latch drops the low side
      apb(1'b1, 12'h014, 32'h0000_0007);
      brake <= 1'b1;
      start <= 1'b1;
      cyc(60);
      chk({31'h0, lse}, 1, "brake idles timer");
      brake <= 1'b0;
      cyc(15);
      chk({31'h0, lse}, 1, "too early");
      for (i = 0; i < 40 && lse !== 1'b0; i++) @(posedge clk);
      chk({31'h0, lse}, 0, "low side off");
      chk({31'h0, irq}, 1, "stall irq");
      apb(1'b1, 12'h010, 32'h0000_0001);
      apb(1'b0, 12'h00C, 0); chk(rd & 32'h0000_0004, 32'h0000_0004, "latch held");
      chk({31'h0, lse}, 0, "still off");
      // Long period so lock pull-in below never trips the guard
      apb(1'b1, 12'h000, 32'h0000_1000);
      start <= 1'b0;
      cyc(3);
      start <= 1'b1;
      cyc(3);
      chk({31'h0, lse}, 1, "stop cleared latch");
      $display("test stall done");
      // Lock with short lock pulses masked
      fb_on <= 1'b1;
      for (i = 0; i < 400 && lock !== 1'b0; i++) @(posedge clk);
      chk({31'h0, lock}, 0, "lock shown");
      apb(1'b0, 12'h00C, 0); chk(rd & 32'h0000_0007, 32'h0000_0001, "raw lock");
      apb(1'b0, 12'h010, 0); chk(rd & 32'h0000_0004, 32'h0000_0004, "lock gained irq");
      cyc(80);
      chk({31'h0, lse}, 1, "locked, no stall");
      // Unlock filter mode and a 64-cycle mask time keep the lock steady
      sel <= 1'b0;
      // A closed window gives a raw unlock of about one period, under 64
      apb(1'b1, 12'h004, 32'h0000_0040);
      apb(1'b1, 12'h008, 32'h0000_0000);
      cyc(34);
      chk({31'h0, lock}, 0, "unlock spike masked");
      apb(1'b1, 12'h008, 32'h0000_0100);
      cyc(34);
      chk({31'h0, lock}, 0, "no unlock spikes");
      // No mask time: the same unlock now passes straight through
      apb(1'b1, 12'h004, 32'h0000_0000);
      apb(1'b1, 12'h008, 32'h0000_0000);
      cyc(34);
      chk({31'h0, lock}, 1, "unlock passes");
      apb(1'b1, 12'h008, 32'h0000_0100);
      cyc(34);
      chk({31'h0, lock}, 0, "relock passes");
      $display("test lock done");
      // Grounded timer node parks the logic
      node <= 1'b0;
      cyc(3);
      chk({31'h0, spd}, 0, "speed off");
      chk({31'h0, lock}, 1, "indicator parked");
      node <= 1'b1;
      $display("test node done");
      report_and_stop;
   end
endmodule : test_motor_lock_mask_and_stall_guard
